//--- common/fji_pkg.sv
/*
  Shared constants for the far jump and file increment execution block:
  register offsets, field positions, opcodes, reset values and phase codes.
  Assumes a 32-bit APB register port with byte addresses.
*/
package fji_pkg;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_WORK    = 12'h004;
  localparam logic [11:0] REG_BANK    = 12'h008;
  localparam logic [11:0] REG_FLAGS   = 12'h00C;
  localparam logic [11:0] REG_PC      = 12'h010;
  localparam logic [11:0] REG_IDXBASE = 12'h014;
  localparam logic [11:0] REG_EXEC    = 12'h018;

  // Control and execution status fields
  localparam int unsigned CTRL_EXT_BIT  = 0;
  localparam int unsigned EXEC_NOP_BIT  = 0;
  localparam int unsigned EXEC_BAD_BIT  = 1;
  localparam int unsigned EXEC_PH_LSB   = 4;

  // Arithmetic flag positions
  localparam int unsigned FLG_C  = 0;
  localparam int unsigned FLG_DC = 1;
  localparam int unsigned FLG_Z  = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned FLG_N  = 4;
  localparam int unsigned FLG_W  = 5;

  // Instruction encodings
  localparam logic [7:0]  JMP1_OPC   = 8'hEF;
  localparam logic [3:0]  JMP2_NIB   = 4'hF;
  localparam logic [5:0]  INC_OPC    = 6'h0A;
  localparam int unsigned INC_D_BIT  = 9;
  localparam int unsigned INC_A_BIT  = 8;
  localparam logic [19:0] JUMP_MAX   = 20'hFFFFF;

  // File address resolution
  localparam logic [7:0]  IDX_LIMIT    = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACC_LO_BANK  = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK  = 4'hF;

  // Reset values and steps
  localparam logic [20:0] RST_PC    = 21'h000000;
  localparam logic [7:0]  RST_W     = 8'h00;
  localparam logic [4:0]  RST_FLAGS = 5'h00;
  localparam logic [3:0]  RST_BANK  = 4'h0;
  localparam logic [11:0] RST_IDX   = 12'h000;
  localparam logic [20:0] PC_STEP   = 21'h000002;

  // Instruction cycle phases, one-hot
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } fji_phase_t;

endpackage : fji_pkg

//--- design/fji_inc_alu.sv
/*
  Incrementer with flag generation for the file increment.
  Purely combinational; the caller registers the result.
*/
module fji_inc_alu (
  // Operand
  input  wire logic [7:0] operand,
  // Result and flags
  output logic      [7:0] sum,
  output logic            carry,
  output logic            halfCarry,
  output logic            negative,
  output logic            signedWrap,
  output logic            zero
);

  logic [8:0] wide;

  always_comb begin
    wide       = {1'b0, operand} + 9'h001;
    sum        = wide[7:0];
    carry      = wide[8];
    halfCarry  = &operand[3:0];
    // Only 7Fh wraps into the negative range
    signedWrap = (operand == 8'h7F);
    negative   = wide[7];
    zero       = (wide[7:0] == 8'h00);
  end

endmodule : fji_inc_alu

//--- design/fji_addr_resolve.sv
/*
  Resolves the 8-bit file address of a byte instruction into a 12-bit
  data memory address: banked, access bank or indexed literal offset.
  Combinational; inputs come from the decode phase.
*/
module fji_addr_resolve (
  // Instruction fields
  input  wire logic [7:0]  fileAddr,
  input  wire logic        bankAccess,
  // Core state
  input  wire logic        extEnable,
  input  wire logic [3:0]  bankSelect,
  input  wire logic [11:0] indexBase,
  // Result
  output logic      [11:0] dataAddr,
  output logic             indexed
);

  always_comb begin
    indexed = extEnable && !bankAccess && (fileAddr <= fji_pkg::IDX_LIMIT);
    if (bankAccess) begin
      dataAddr = {bankSelect, fileAddr};
    end else if (indexed) begin
      dataAddr = indexBase + {4'h0, fileAddr};
    end else if (fileAddr < fji_pkg::ACCESS_SPLIT) begin
      dataAddr = {fji_pkg::ACC_LO_BANK, fileAddr};
    end else begin
      dataAddr = {fji_pkg::ACC_HI_BANK, fileAddr};
    end
  end

endmodule : fji_addr_resolve

//--- design/fji_exec.sv
/*
  Execution unit for the two-word far jump and the one-word file increment,
  run over four clock phases per instruction cycle, with an APB register port.
  Assumes the fetch logic presents words on instrWord with instrValid on the
  same clock, and a data memory that returns read data in the same clock that dmAddr is presented.
*/
// How it works
// RULE1: The far jump goes to any word address of program memory with no condition tested.
// RULE2: The far jump puts its 20-bit literal into pc bits 20 to 1, bit 0 staying zero.
// RULE3: The far jump takes two cycles, the second a no-operation discarding the prefetched word.
// RULE4: Word one of the far jump has upper byte EFh with target bits 7-0, word two nibble Fh.
// RULE5: Any far jump literal from zero to FFFFFh is accepted.
// RULE6: The file increment reads the addressed register, adds one and passes it on.
// RULE7: The file increment sets carry, half carry, negative, signed wrap and zero from its result.
// RULE8: The file increment has opcode 001010, then destination, bank bit and 8-bit address.
// RULE9: With the bank bit clear the address falls in the fixed access bank.
// RULE10: With the bank bit set the bank select pointer gives the upper address bits.
// RULE11: Extended mode, bank bit clear and address at most 5Fh selects indexed literal offset.
// RULE12: The file increment is one word and one cycle: decode, read, compute, write.
// RULE13: The far jump leaves all arithmetic flags unchanged.
module fji_exec (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Instruction stream
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  output logic             instrReady,
  output logic      [20:0] pc,
  // Data memory
  output logic      [11:0] dmAddr,
  output logic             dmRdEn,
  input  wire logic [7:0]  dmRdData,
  output logic             dmWrEn,
  output logic      [7:0]  dmWrData
);

  typedef struct packed {
    fji_pkg::fji_phase_t phase;
    logic        nopCycle;
    logic        discard;
    logic        isJump;
    logic        isInc;
    logic        indexed;
    logic        badWord;
    logic [15:0] instr;
    logic [7:0]  opData;
    logic [7:0]  result;
    logic [4:0]  newFlags;
    logic [4:0]  status;
    logic [7:0]  w;
    logic [3:0]  bank_select_pointer;
    logic [20:0] pc;
    logic        extEn;
    logic [11:0] idxBase;
    logic [11:0] dmAddr;
    logic        dmWrEn;
    logic [7:0]  dmWrData;
    logic        rdValid;
    logic [31:0] prdata;
  } fji_state_t;

  localparam fji_state_t ST_RESET = '{
    phase:    fji_pkg::PH_Q1,
    nopCycle: 1'b0,
    discard:  1'b0,
    isJump:   1'b0,
    isInc:    1'b0,
    indexed:  1'b0,
    badWord:  1'b0,
    instr:    16'h0000,
    opData:   8'h00,
    result:   8'h00,
    newFlags: 5'h00,
    status:   fji_pkg::RST_FLAGS,
    w:        fji_pkg::RST_W,
    bank_select_pointer:      fji_pkg::RST_BANK,
    pc:       fji_pkg::RST_PC,
    extEn:    1'b0,
    idxBase:  fji_pkg::RST_IDX,
    dmAddr:   12'h000,
    dmWrEn:   1'b0,
    dmWrData: 8'h00,
    rdValid:  1'b0,
    prdata:   32'h00000000
  };

  logic [1:0]  rstPipe;
  logic        rstSync;
  fji_state_t  st;
  fji_state_t  next_st;
  logic [11:0] resolvedAddr;
  logic        resolvedIndexed;
  logic [7:0]  aluSum;
  logic        aluC;
  logic        aluDc;
  logic        aluN;
  logic        aluOv;
  logic        aluZ;
  logic        mapped;
  logic [31:0] readMux;
  logic        apbWrite;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  fji_addr_resolve u_resolve (
    .fileAddr   (instrWord[7:0]),
    .bankAccess (instrWord[fji_pkg::INC_A_BIT]),
    .extEnable  (st.extEn),
    .bankSelect (st.bank_select_pointer),
    .indexBase  (st.idxBase),
    .dataAddr   (resolvedAddr),
    .indexed    (resolvedIndexed)
  );

  fji_inc_alu u_alu (
    .operand    (st.opData),
    .sum        (aluSum),
    .carry      (aluC),
    .halfCarry  (aluDc),
    .negative   (aluN),
    .signedWrap (aluOv),
    .zero       (aluZ)
  );

  // Register read mux and decode
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      fji_pkg::REG_CTRL:    readMux = {31'h0, st.extEn};
      fji_pkg::REG_WORK:    readMux = {24'h0, st.w};
      fji_pkg::REG_BANK:    readMux = {28'h0, st.bank_select_pointer};
      fji_pkg::REG_FLAGS:   readMux = {27'h0, st.status};
      fji_pkg::REG_PC:      readMux = {11'h0, st.pc};
      fji_pkg::REG_IDXBASE: readMux = {20'h0, st.idxBase};
      fji_pkg::REG_EXEC:    readMux = {24'h0, st.phase, 2'b00, st.badWord, st.nopCycle};
      default: begin
        readMux = 32'h00000000;
        mapped  = 1'b0;
      end
    endcase
  end

  assign pready   = clkEn && rstSync && psel && penable && (pwrite || st.rdValid);
  assign pslverr  = pready && !mapped;
  assign apbWrite = pready && pwrite && mapped;
  assign prdata   = st.prdata;

  always_comb begin
    next_st = st;
    if (clkEn) begin
      next_st.rdValid = psel && !pready;
      if (psel && !pwrite && !st.rdValid) begin
        next_st.prdata = readMux;
      end
      if (apbWrite) begin
        case (paddr)
          fji_pkg::REG_CTRL:    next_st.extEn   = pwdata[fji_pkg::CTRL_EXT_BIT];
          fji_pkg::REG_WORK:    next_st.w       = pwdata[7:0];
          fji_pkg::REG_BANK:    next_st.bank_select_pointer     = pwdata[3:0];
          fji_pkg::REG_FLAGS:   next_st.status  = pwdata[fji_pkg::FLG_W-1:0];
          fji_pkg::REG_PC:      next_st.pc      = {pwdata[20:1], 1'b0};
          fji_pkg::REG_IDXBASE: next_st.idxBase = pwdata[11:0];
          fji_pkg::REG_EXEC: begin
            if (pwdata[fji_pkg::EXEC_BAD_BIT]) begin
              next_st.badWord = 1'b0;
            end
          end
          default: next_st.extEn = st.extEn;
        endcase
      end
      // Execution after the bus so the core wins a same-cycle conflict
      case (st.phase)
        fji_pkg::PH_Q1: begin
          if (instrValid) begin
            next_st.phase = fji_pkg::PH_Q2;
            if (st.nopCycle) begin
              // Prefetched word dropped [RULE3]
              next_st.nopCycle = 1'b0;
              next_st.discard  = 1'b1;
              next_st.isJump   = 1'b0;
              next_st.isInc    = 1'b0;
            end else begin
              next_st.discard = 1'b0;
              next_st.instr   = instrWord;
              next_st.isJump  = (instrWord[15:8] == fji_pkg::JMP1_OPC); // [RULE4]
              next_st.isInc   = (instrWord[15:10] == fji_pkg::INC_OPC); // [RULE8] [RULE12]
              next_st.dmAddr  = resolvedAddr; // [RULE9] [RULE10]
              next_st.indexed = resolvedIndexed; // [RULE11]
            end
          end
        end
        fji_pkg::PH_Q2: begin
          if (st.isInc) begin
            next_st.opData = dmRdData; // [RULE6] [RULE12]
          end
          next_st.phase = fji_pkg::PH_Q3;
        end
        fji_pkg::PH_Q3: begin
          if (st.isInc) begin
            next_st.result   = aluSum; // [RULE6]
            next_st.newFlags = '0;
            next_st.newFlags[fji_pkg::FLG_C]  = aluC; // [RULE7]
            next_st.newFlags[fji_pkg::FLG_DC] = aluDc;
            next_st.newFlags[fji_pkg::FLG_Z]  = aluZ;
            next_st.newFlags[fji_pkg::FLG_OV] = aluOv;
            next_st.newFlags[fji_pkg::FLG_N]  = aluN;
            next_st.dmWrEn   = st.instr[fji_pkg::INC_D_BIT]; // [RULE8]
            next_st.dmWrData = aluSum;
          end
          next_st.phase = fji_pkg::PH_Q4;
        end
        fji_pkg::PH_Q4: begin
          if (st.isJump) begin
            // Waits here for the second word
            if (instrValid) begin
              next_st.phase = fji_pkg::PH_Q1;
              if (instrWord[15:12] == fji_pkg::JMP2_NIB) begin
                // Full 20-bit range, no condition, flags untouched [RULE1] [RULE2] [RULE5] [RULE13]
                next_st.pc       = {instrWord[11:0], st.instr[7:0], 1'b0};
                next_st.nopCycle = 1'b1; // [RULE3]
              end else begin
                next_st.badWord = 1'b1;
                next_st.pc      = st.pc + fji_pkg::PC_STEP;
              end
            end
          end else begin
            next_st.phase = fji_pkg::PH_Q1;
            if (st.isInc) begin
              if (!st.instr[fji_pkg::INC_D_BIT]) begin
                next_st.w = st.result; // [RULE8]
              end
              next_st.status = st.newFlags; // [RULE7]
              next_st.dmWrEn = 1'b0;
            end
            if (!st.discard) begin
              next_st.pc = st.pc + fji_pkg::PC_STEP;
            end
          end
        end
        default: next_st.phase = fji_pkg::PH_Q1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign instrReady = clkEn && rstSync &&
                      ((st.phase == fji_pkg::PH_Q1) ||
                       ((st.phase == fji_pkg::PH_Q4) && st.isJump));
  assign pc       = st.pc;
  assign dmAddr   = st.dmAddr;
  assign dmRdEn   = (st.phase == fji_pkg::PH_Q2) && st.isInc;
  assign dmWrEn   = st.dmWrEn;
  assign dmWrData = st.dmWrData;

  default clocking cbDef @(posedge sys_clk); endclocking
  default disable iff (!rstSync);

  sequence sJumpLast;
    (st.phase == fji_pkg::PH_Q4) && st.isJump && instrValid && clkEn &&
    (instrWord[15:12] == fji_pkg::JMP2_NIB);
  endsequence

  sequence sIncDecode;
    (st.phase == fji_pkg::PH_Q1) && !st.nopCycle && instrValid && clkEn &&
    (instrWord[15:10] == fji_pkg::INC_OPC);
  endsequence

  AST_JUMP_TARGET: assert property ( // [RULE2]
    (sJumpLast and !apbWrite) |=>
      st.pc == {$past(instrWord[11:0]), $past(st.instr[7:0]), 1'b0})
    else $error("far jump target not loaded into pc");

  AST_JUMP_NOP_CYCLE: assert property ( // [RULE3]
    sJumpLast ##1 (instrValid && clkEn) |=> st.discard && !st.isJump && !st.isInc)
    else $error("far jump second cycle did not discard the prefetched word");

  AST_JUMP_DECODE: assert property ( // [RULE4]
    (st.phase == fji_pkg::PH_Q1) && !st.nopCycle && instrValid && clkEn &&
    (instrWord[15:8] == fji_pkg::JMP1_OPC) |=> st.isJump && (st.phase == fji_pkg::PH_Q2))
    else $error("far jump first word not decoded");

  AST_JUMP_FLAGS: assert property ( // [RULE13]
    (sJumpLast and !apbWrite) |=> st.status == $past(st.status))
    else $error("far jump changed the flags");

  AST_INC_SUM: assert property ( // [RULE6]
    (st.phase == fji_pkg::PH_Q3) && st.isInc && clkEn |=> st.result == st.opData + 8'h01)
    else $error("increment result wrong");

  AST_INC_FLAGS: assert property ( // [RULE7]
    (st.phase == fji_pkg::PH_Q4) && st.isInc && clkEn && (st.opData == 8'hFF) && !apbWrite
    |=> st.status[fji_pkg::FLG_Z] && st.status[fji_pkg::FLG_C] && st.status[fji_pkg::FLG_DC])
    else $error("increment of all ones did not set zero, carry and half carry");

  AST_INC_TO_FILE: assert property ( // [RULE8]
    (st.phase == fji_pkg::PH_Q4) && st.isInc
    |-> (dmWrEn == st.instr[fji_pkg::INC_D_BIT]) && (!dmWrEn || (dmWrData == st.result)))
    else $error("increment write back to file wrong");

  AST_INC_TO_W: assert property ( // [RULE8]
    (st.phase == fji_pkg::PH_Q4) && st.isInc && clkEn && !st.instr[fji_pkg::INC_D_BIT] &&
    !apbWrite |=> st.w == $past(st.result))
    else $error("increment result not placed in working register");

  AST_ACCESS_BANK: assert property ( // [RULE9]
    (st.phase == fji_pkg::PH_Q2) && st.isInc && !st.instr[fji_pkg::INC_A_BIT] && !st.indexed
    |-> (dmAddr[11:8] == ((st.instr[7:0] < fji_pkg::ACCESS_SPLIT) ?
                          fji_pkg::ACC_LO_BANK : fji_pkg::ACC_HI_BANK)) &&
        (dmAddr[7:0] == st.instr[7:0]))
    else $error("access bank address wrong");

  AST_BANKED: assert property ( // [RULE10]
    (st.phase == fji_pkg::PH_Q2) && st.isInc && st.instr[fji_pkg::INC_A_BIT] && $stable(st.bank_select_pointer)
    |-> dmAddr == {st.bank_select_pointer, st.instr[7:0]})
    else $error("banked address does not use the bank select pointer");

  AST_INDEXED: assert property ( // [RULE11]
    (st.phase == fji_pkg::PH_Q2) && st.isInc && st.indexed && $stable(st.idxBase)
    |-> !st.instr[fji_pkg::INC_A_BIT] && (st.instr[7:0] <= fji_pkg::IDX_LIMIT) &&
        (dmAddr == st.idxBase + {4'h0, st.instr[7:0]}))
    else $error("indexed mode chosen outside its range");

  AST_INC_ONE_CYCLE: assert property ( // [RULE12]
    sIncDecode ##1 clkEn ##1 clkEn ##1 clkEn |=> st.phase == fji_pkg::PH_Q1)
    else $error("increment did not finish in one instruction cycle");

endmodule : fji_exec

//--- dv/fji_exec_tb.sv
/*
  Self-checking bench for fji_exec: APB access, file increment address
  modes and flags, far jump targets, the dropped prefetch.
  Assumes a data memory that answers in the same cycle that dmAddr is presented.
*/
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin err_total++; \
  $display("[ERR] %s exp=%h got=%h", nm, ex, gt); end end

module fji_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk    = 1'b0;
  logic        reset_n    = 1'b0;
  logic        clkEn      = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] instrWord  = 16'h0000;
  logic        instrValid = 1'b0;
  logic        instrReady;
  logic [20:0] pc;
  logic [11:0] dmAddr;
  logic        dmRdEn;
  logic        dmWrEn;
  logic [7:0]  dmRdData;
  logic [7:0]  dmWrData;
  logic [7:0]  mem [0:4095];
  int          err_total  = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  fji_exec u_fji_exec (
    .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instrWord(instrWord), .instrValid(instrValid), .instrReady(instrReady), .pc(pc),
    .dmAddr(dmAddr), .dmRdEn(dmRdEn), .dmRdData(dmRdData),
    .dmWrEn(dmWrEn), .dmWrData(dmWrData)
  );

  always #5 sys_clk = ~sys_clk;

  // Data memory: asynchronous read, written at the edge ending Q4
  assign dmRdData = mem[dmAddr];
  always @(posedge sys_clk) begin
    if (dmWrEn === 1'b1) mem[dmAddr] <= dmWrData;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, ex, r & m)
  endtask : rdchk

  task automatic issue(input logic [15:0] w);
    // Leading edge keeps the release of an earlier call in its own step
    @(posedge sys_clk);
    instrWord  <= w;
    instrValid <= 1'b1;
    do @(posedge sys_clk); while (instrReady !== 1'b1);
    instrValid <= 1'b0;
  endtask : issue

  // One increment, watching its read and write over the four phases
  task automatic run_inc(input logic [15:0] w, input logic [11:0] ea, input logic d,
                         input logic [7:0] ev);
    logic        sawRd;
    logic        sawWr;
    logic [11:0] a;
    logic [7:0]  v;
    logic [20:0] pc0;
    pc0   = pc;
    sawRd = 1'b0;
    sawWr = 1'b0;
    a     = 12'h000;
    v     = 8'h00;
    issue(w);
    repeat (4) begin
      @(negedge sys_clk);
      if (dmRdEn === 1'b1) begin
        sawRd = 1'b1;
        a     = dmAddr;
      end
      if (dmWrEn === 1'b1) begin
        sawWr = 1'b1;
        v     = dmWrData;
      end
      @(posedge sys_clk);
    end
    `CHK("read seen", 1'b1, sawRd)
    `CHK("data addr", ea, a)
    `CHK("write seen", d, sawWr)
    if (d) `CHK("write data", ev, v)
    `CHK("pc step", pc0 + 21'h000002, pc)
  endtask : run_inc

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    `CHK("pc at reset", 21'h000000, pc)
    rdchk("w reset", fji_pkg::REG_WORK, 32'hFFFFFFFF, 32'h0);
    rdchk("flags reset", fji_pkg::REG_FLAGS, 32'h1F, 32'h0);
    rdchk("bank reset", fji_pkg::REG_BANK, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 12'h020, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    wr(fji_pkg::REG_BANK, 32'h3);
    rdchk("bank back", fji_pkg::REG_BANK, 32'hFFFFFFFF, 32'h3);
  endtask : t_reset

  task automatic t_inc_flags();
    logic [7:0] ops [4] = '{8'hFF, 8'h7F, 8'h0F, 8'h41};
    logic [4:0] fl  [4] = '{5'h07, 5'h1A, 5'h02, 5'h00};
    wr(fji_pkg::REG_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      mem[12'h010] = ops[i];
      run_inc(16'h2810, 12'h010, 1'b0, 8'h00);
      rdchk("w result", fji_pkg::REG_WORK, 32'hFFFFFFFF, {24'h0, ops[i] + 8'h01});
      rdchk("inc flags", fji_pkg::REG_FLAGS, 32'h1F, {27'h0, fl[i]});
    end
  endtask : t_inc_flags

  task automatic t_banks();
    mem[12'h345] = 8'h41;
    mem[12'hF80] = 8'h10;
    mem[12'h25F] = 8'h20;
    mem[12'hF60] = 8'h30;
    mem[12'h310] = 8'h40;
    run_inc(16'h2B45, 12'h345, 1'b1, 8'h42);
    `CHK("mem back", 8'h42, mem[12'h345])
    run_inc(16'h2A80, 12'hF80, 1'b1, 8'h11);
    wr(fji_pkg::REG_CTRL, 32'h1);
    wr(fji_pkg::REG_IDXBASE, 32'h200);
    run_inc(16'h2A5F, 12'h25F, 1'b1, 8'h21);
    run_inc(16'h2A60, 12'hF60, 1'b1, 8'h31);
    run_inc(16'h2B10, 12'h310, 1'b1, 8'h41);
  endtask : t_banks

  task automatic t_jump();
    logic [19:0] tg [3] = '{20'h12A34, 20'h00000, fji_pkg::JUMP_MAX};
    logic        seen;
    wr(fji_pkg::REG_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(fji_pkg::REG_FLAGS, 32'h15);
      issue({fji_pkg::JMP1_OPC, tg[i][7:0]});
      issue({fji_pkg::JMP2_NIB, tg[i][19:8]});
      issue(16'h2B45);
      seen = 1'b0;
      repeat (4) begin
        @(negedge sys_clk);
        if (dmRdEn === 1'b1 || dmWrEn === 1'b1) seen = 1'b1;
        @(posedge sys_clk);
      end
      `CHK("prefetch dropped", 1'b0, seen)
      `CHK("jump pc", {tg[i], 1'b0}, pc)
      rdchk("jump flags", fji_pkg::REG_FLAGS, 32'h1F, 32'h15);
      run_inc(16'h2810, 12'h010, 1'b0, 8'h00);
    end
    issue({fji_pkg::JMP1_OPC, 8'h00});
    issue(16'h1234);
    rdchk("bad word", fji_pkg::REG_EXEC, 32'h2, 32'h2);
    wr(fji_pkg::REG_EXEC, 32'h2);
    rdchk("bad cleared", fji_pkg::REG_EXEC, 32'h2, 32'h0);
  endtask : t_jump

  // Clock enable low in mid-increment freezes the whole instruction
  task automatic t_freeze();
    logic [20:0] pc0;
    pc0 = pc;
    mem[12'h010] = 8'h05;
    issue(16'h2A10);
    clkEn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    `CHK("frozen pc", pc0, pc)
    `CHK("frozen phase", 1'b1, dmRdEn)
    `CHK("frozen mem", 8'h05, mem[12'h010])
    clkEn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("thawed mem", 8'h06, mem[12'h010])
    `CHK("thawed pc", pc0 + 21'h000002, pc)
  endtask : t_freeze

  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_inc_flags();
    t_banks();
    t_jump();
    t_freeze();
    close_out();
  end
endmodule : fji_exec_tb
